/* File: inc/host_port_pkg.sv */
// shared constants for the host port and interrupt logic
package host_port_pkg;
  // ----------------------------------------------------------------
  // register offsets on the host bus (8-bit address space)
  // ----------------------------------------------------------------
  localparam logic [7:0] status_addr = 8'h20; // read: status, write: mask
  localparam logic [7:0] ext_addr = 8'h24; // extended interrupt flags
  localparam logic [7:0] code_addr = 8'h31; // received code
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int ext_bit = 0; // extended summary flag
  localparam int code_bit = 2; // code change flag
  localparam logic [7:0] mask_reset = 8'h00;
  localparam logic [7:0] sticky_bits = 8'h05; // flags a status read leaves alone
  // ----------------------------------------------------------------
  // timing counts
  // ----------------------------------------------------------------
  // the host can only show its strap one cycle after release, and the edge stage
  // must have settled too, else a strobe-type strap reads as an edge into mux
  localparam int strap_cycles = 5; // cycles after reset before the strap is taken
  localparam int strobe_cycles = 8; // host strobe width, covers the 2-flop sync
  localparam int dclk_half = 4; // data clock half period in clk cycles
  // ----------------------------------------------------------------
  // bus interface types, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    mode_strobe = 3'b001, // read_not_write plus data strobe
    mode_split = 3'b010, // separate read and write strobes
    mode_mux = 3'b100 // multiplexed address and data
  } bus_mode_t;
endpackage : host_port_pkg

/* File: inc/host_port_if.sv */
// pin bundle between the host processor and the device port
`timescale 1ns/1ps
interface host_port_if;
  // control pins, driven by the host
  logic chip_sel_n;
  logic read_not_write; // doubles as write strobe (low) in split modes
  logic data_strobe_n; // doubles as read strobe (low) in split modes
  logic ale;
  logic [5:0] addr_bits;
  logic data_clock;
  // shared bus, both ends drive with an enable
  logic [7:0] host_bus_o;
  logic host_bus_oe;
  logic [7:0] dev_bus_o;
  logic dev_bus_oe;
  logic [7:0] shared_bus_line;
  // open-drain interrupt, pulled up when nobody drives
  logic irq_o;
  logic irq_oe;
  logic irq_n;
  // wire levels; an idle bus reads as pulled up
  assign shared_bus_line = dev_bus_oe ? dev_bus_o : (host_bus_oe ? host_bus_o : 8'hff);
  assign irq_n = irq_oe ? irq_o : 1'b1;
  modport device (
    input chip_sel_n, read_not_write, data_strobe_n, ale, addr_bits, data_clock,
    input shared_bus_line, irq_n,
    output dev_bus_o, dev_bus_oe, irq_o, irq_oe
  );
  modport host (
    output chip_sel_n, read_not_write, data_strobe_n, ale, addr_bits, data_clock,
    output host_bus_o, host_bus_oe,
    input shared_bus_line, irq_n
  );
endinterface : host_port_if

/* File: hdl/host_port_device.sv */
// device end: bus slave, mode selection and interrupt aggregation
`timescale 1ns/1ps
module host_port_device
  import host_port_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // pins toward the host
  host_port_if.device pins,
  // event sources from the core
  input wire logic [7:1] src_event,
  input wire logic [7:0] ext_event,
  input wire logic [7:0] code_value,
  // write port for all other registers
  output logic wr_strobe,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  // state shown to the core
  output bus_mode_t bus_mode,
  output logic irq_active
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [13:0] sync1; // first stage, read only by sync2
  logic [13:0] sync2;
  logic [13:0] sync3; // previous sample for edge detection
  logic [7:0] bus1;
  logic [7:0] bus2;
  wire [13:0] raw_pins = {pins.data_clock, pins.ale, pins.data_strobe_n,
                          pins.read_not_write, pins.chip_sel_n, 3'h0, pins.addr_bits};
  // two flops per pin, then one more for edges
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      // select and both strobes start at their idle high level, so no false edge
      sync1 <= 14'h0e00;
      sync2 <= 14'h0e00;
      sync3 <= 14'h0e00;
      bus1 <= 8'h00;
      bus2 <= 8'h00;
    end else begin
      sync1 <= raw_pins;
      sync2 <= sync1;
      sync3 <= sync2;
      bus1 <= pins.shared_bus_line;
      bus2 <= bus1;
    end
  end
  // named views of the synchronised pins
  wire dclk_rise = sync2[13] & ~sync3[13];
  wire ale_s = sync2[12];
  wire ale_edge = sync2[12] ^ sync3[12];
  wire strobe_s = sync2[11];
  wire strobe_rise = sync2[11] & ~sync3[11];
  wire rw_s = sync2[10];
  wire rw_rise = sync2[10] & ~sync3[10];
  wire cs_s = sync2[9];
  wire [5:0] addr_pins_s = sync2[5:0];
  // ----------------------------------------------------------------
  // interface type selection
  // ----------------------------------------------------------------
  logic [2:0] strap_cnt; // waits until the sync chain holds real pin levels
  logic strap_done;
  // strap taken once after reset; any later edge locks to mux
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strap_cnt <= 3'h0;
      strap_done <= 1'b0;
      bus_mode <= mode_split;
    end else if (!strap_done) begin
      if (strap_cnt == 3'(strap_cycles - 1)) begin
        strap_done <= 1'b1;
        bus_mode <= ale_s ? mode_strobe : mode_split;
      end else begin
        strap_cnt <= strap_cnt + 3'h1;
      end
    end else if (ale_edge) begin
      bus_mode <= mode_mux;
    end
  end
  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  wire is_strobe = (bus_mode == mode_strobe);
  wire selected = strap_done & ~cs_s;
  // strobe type: one strobe, direction from read_not_write
  wire rd_active = selected & ~strobe_s & (~is_strobe | rw_s);
  wire rd_end = selected & strobe_rise & (~is_strobe | rw_s);
  wire wr_end = selected & (is_strobe ? (strobe_rise & ~rw_s) : rw_rise);
  logic [7:0] mux_addr; // address latched from the shared bus
  // mux mode takes the address off the bus, other modes from the pins
  wire [7:0] cur_addr = (bus_mode == mode_mux) ? mux_addr : {2'b00, addr_pins_s};
  wire hit_status = (cur_addr == status_addr);
  wire hit_ext = (cur_addr == ext_addr);
  wire hit_code = (cur_addr == code_addr);
  // address latch follows the bus while the latch strobe is high
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mux_addr <= 8'h00;
    end else if (bus_mode == mode_mux && ale_s) begin
      mux_addr <= bus2;
    end
  end
  // ----------------------------------------------------------------
  // interrupt flags
  // ----------------------------------------------------------------
  logic [7:0] mask; // one suppresses the source
  logic [7:1] pending; // primary events, held even while masked
  logic [7:0] ext_flags;
  wire ext_summary_flag = |ext_flags;
  wire [7:0] all_flags = {pending, ext_summary_flag};
  // masked direct sources read zero; summary and code flags always show
  wire [7:0] irq_status_reg = all_flags & (~mask | sticky_bits);
  // a status read clears unmasked bits only, never the two sticky ones
  wire [7:0] status_clear = {8{rd_end & hit_status}} & ~mask & ~sticky_bits;
  wire code_clear = rd_end & hit_code;
  wire ext_clear = rd_end & hit_ext;
  // code flag has its own clear; all others use the status clear
  wire [7:1] next_pending_clr = status_clear[7:1] |
                                (code_clear ? 7'(1 << (code_bit - 1)) : 7'h00);
  // every unmasked flag, including summary and code, asks for service
  wire irq_request = |(all_flags & ~mask);
  // new events win over a clear in the same cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pending <= 7'h00;
      ext_flags <= 8'h00;
    end else begin
      pending <= (pending & ~next_pending_clr) | src_event;
      ext_flags <= (ext_clear ? 8'h00 : ext_flags) | ext_event;
    end
  end
  // ----------------------------------------------------------------
  // writes
  // ----------------------------------------------------------------
  // mask lives at the status offset; other writes go to the core
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mask <= mask_reset;
      wr_strobe <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_strobe <= wr_end & ~hit_status;
      if (wr_end) begin
        wr_addr <= cur_addr;
        wr_data <= bus2; // host holds data past the strobe edge
      end
      if (wr_end && hit_status) begin
        mask <= bus2;
      end
    end
  end
  // ----------------------------------------------------------------
  // read data and pin drivers
  // ----------------------------------------------------------------
  // unmapped reads return zero
  wire [7:0] rd_data = hit_status ? irq_status_reg :
                       hit_ext ? ext_flags :
                       hit_code ? code_value :
                       hit_status ? mask : 8'h00;
  // bus driven only while a selected read strobe is low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pins.dev_bus_o <= 8'h00;
      pins.dev_bus_oe <= 1'b0;
    end else begin
      pins.dev_bus_o <= rd_data;
      pins.dev_bus_oe <= rd_active;
    end
  end
  // open drain: only ever pulls low, moved on data clock rises
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pins.irq_o <= 1'b0;
      pins.irq_oe <= 1'b0;
      irq_active <= 1'b0;
    end else if (dclk_rise) begin
      pins.irq_o <= 1'b0;
      pins.irq_oe <= irq_request;
      irq_active <= irq_request;
    end
  end
endmodule : host_port_device

/* File: hdl/host_port_host.sv */
// host end: drives register accesses in the chosen bus type
`timescale 1ns/1ps
module host_port_host
  import host_port_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // pins toward the device
  host_port_if.host pins,
  // bus type this host uses
  input wire bus_mode_t host_mode,
  // access requests
  input wire logic req,
  input wire logic req_write,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic busy,
  output logic done,
  output logic [7:0] rd_data,
  // interrupt seen at the pin
  output logic irq_seen
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    st_idle = 4'b0001, // bus quiet
    st_addr = 4'b0010, // address phase (latch strobe high in mux)
    st_strobe = 4'b0100, // strobe held low
    st_hold = 4'b1000 // strobe released, select and data held
  } host_state_t;
  host_state_t state;
  logic [3:0] cnt;
  logic is_write;
  logic [7:0] data_hold;
  logic [7:0] bus1;
  logic [7:0] bus2;
  logic irq1;
  logic irq2;
  logic [2:0] dclk_cnt;
  wire is_mux = (host_mode == mode_mux);
  wire is_strobe = (host_mode == mode_strobe);
  wire strobe_last = (cnt == 4'(strobe_cycles - 1));
  wire hold_last = (cnt == 4'(strobe_cycles - 1));
  // ----------------------------------------------------------------
  // data clock divider
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dclk_cnt <= 3'h0;
      pins.data_clock <= 1'b0;
    end else if (dclk_cnt == 3'(dclk_half - 1)) begin
      dclk_cnt <= 3'h0;
      pins.data_clock <= ~pins.data_clock;
    end else begin
      dclk_cnt <= dclk_cnt + 3'h1;
    end
  end
  // pin inputs pass two flops; the interrupt gets a third for irq_seen
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bus1 <= 8'h00;
      bus2 <= 8'h00;
      irq1 <= 1'b0;
      irq2 <= 1'b0;
      irq_seen <= 1'b0;
    end else begin
      bus1 <= pins.shared_bus_line;
      bus2 <= bus1;
      irq1 <= ~pins.irq_n;
      irq2 <= irq1;
      irq_seen <= irq2;
    end
  end
  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= st_idle;
      cnt <= 4'h0;
      is_write <= 1'b0;
      data_hold <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
      rd_data <= 8'h00;
      pins.chip_sel_n <= 1'b1;
      pins.read_not_write <= 1'b1;
      pins.data_strobe_n <= 1'b1;
      pins.ale <= 1'b0;
      pins.addr_bits <= 6'h00;
      pins.host_bus_o <= 8'h00;
      pins.host_bus_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      // strap level follows the bus type while not pulsing
      if (!is_mux) begin
        pins.ale <= is_strobe;
      end
      unique case (state)
        st_idle: begin
          if (req) begin
            state <= st_addr;
            busy <= 1'b1;
            cnt <= 4'h0;
            is_write <= req_write;
            data_hold <= req_wdata;
            pins.chip_sel_n <= 1'b0;
            pins.addr_bits <= req_addr[5:0];
            pins.read_not_write <= is_strobe ? ~req_write : 1'b1;
            pins.host_bus_o <= req_addr;
            pins.host_bus_oe <= is_mux;
            pins.ale <= is_mux ? 1'b1 : is_strobe;
          end
        end
        st_addr: begin
          cnt <= cnt + 4'h1;
          if (strobe_last) begin
            state <= st_strobe;
            cnt <= 4'h0;
            if (is_mux) begin
              pins.ale <= 1'b0;
            end
            pins.host_bus_o <= data_hold;
            pins.host_bus_oe <= is_write;
            if (is_strobe || !is_write) begin
              pins.data_strobe_n <= 1'b0;
            end else begin
              pins.read_not_write <= 1'b0;
            end
          end
        end
        st_strobe: begin
          cnt <= cnt + 4'h1;
          if (strobe_last) begin
            state <= st_hold;
            cnt <= 4'h0;
            rd_data <= bus2;
            pins.data_strobe_n <= 1'b1;
            if (!is_strobe) begin
              pins.read_not_write <= 1'b1;
            end
          end
        end
        st_hold: begin
          cnt <= cnt + 4'h1;
          if (hold_last) begin
            state <= st_idle;
            busy <= 1'b0;
            done <= 1'b1;
            pins.chip_sel_n <= 1'b1;
            pins.host_bus_oe <= 1'b0;
            pins.read_not_write <= 1'b1;
          end
        end
      endcase
    end
  end
endmodule : host_port_host

/* File: tb/host_port_properties.sv */
// concurrent checks on the pins between host end and device end
`timescale 1ns/1ps
module host_port_properties (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control pins and enables
  input wire logic chip_sel_n,
  input wire logic read_not_write,
  input wire logic data_strobe_n,
  input wire logic ale,
  input wire logic data_clock,
  input wire logic host_bus_oe,
  input wire logic dev_bus_oe,
  input wire logic irq_o,
  input wire logic irq_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // cycles since the data clock rose; saturates so a long gap never wraps
  logic [2:0] since_rise;
  // counter restarts on each sampled data clock rise
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      since_rise <= 3'h7;
    end else if ($rose(data_clock)) begin
      since_rise <= 3'h0;
    end else if (since_rise != 3'h7) begin
      since_rise <= since_rise + 3'h1;
    end
  end
  // ----------------------------------------------------------------
  // multi-step sequences
  // ----------------------------------------------------------------
  sequence s_strobe_low;
    (!data_strobe_n && !chip_sel_n) [*8] ##1 data_strobe_n;
  endsequence
  sequence s_addr_phase;
    (ale && host_bus_oe && !dev_bus_oe) [*8] ##1 !ale;
  endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_irq_low;
    irq_oe |-> !irq_o;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("interrupt pin driven high");
  // sync delay allows a few cycles; the bound also lets in the first two cycles of the low half
  property p_irq_dclk;
    $changed(irq_oe) |-> since_rise < 3'h5;
  endproperty
  a_irq_dclk: assert property (p_irq_dclk) else $error("interrupt moved off clock rise");
  property p_strobe_sel;
    $fell(data_strobe_n) |-> !chip_sel_n;
  endproperty
  a_strobe_sel: assert property (p_strobe_sel) else $error("strobe without select");
  property p_strobe_width;
    $fell(data_strobe_n) |-> s_strobe_low;
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("strobe width wrong");
  property p_addr_phase;
    $rose(ale) && !chip_sel_n |-> s_addr_phase;
  endproperty
  a_addr_phase: assert property (p_addr_phase) else $error("address phase wrong");
  property p_no_fight;
    !(host_bus_oe && dev_bus_oe);
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("both ends drive the bus");
  property p_dev_read;
    dev_bus_oe |-> !chip_sel_n && read_not_write;
  endproperty
  a_dev_read: assert property (p_dev_read) else $error("device drives outside a read");
  property p_write_quiet;
    !read_not_write && !chip_sel_n |-> !dev_bus_oe;
  endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("device drives in a write");
  property p_cs_frame;
    $fell(chip_sel_n) |-> ##23 !chip_sel_n ##1 chip_sel_n;
  endproperty
  a_cs_frame: assert property (p_cs_frame) else $error("select frame length wrong");
endmodule : host_port_properties

/* File: tb/tb_top.sv */
// self-checking bench: host end against device end over the pin bundle
`timescale 1ns/1ps
module tb_top
  import host_port_pkg::*;
;
  // stimulus, all given a value at time zero
  logic clk = 1'b0;
  logic reset = 1'b1;
  bus_mode_t host_mode = mode_mux;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic [7:0] req_addr = 8'h00;
  logic [7:0] req_wdata = 8'h00;
  logic [7:1] src_event = 7'h00;
  logic [7:0] ext_event = 8'h00;
  logic [7:0] code_value = 8'h00;
  // design outputs and captured writes
  logic busy, done, irq_seen, wr_strobe, irq_active;
  logic [7:0] rd_data, wr_addr, wr_data, seen_addr, seen_data;
  bus_mode_t bus_mode;
  int err_count = 0;
  int checked = 0;
  // 125 MHz clock
  always #4 clk = ~clk;
  host_port_if u_host_port_if ();
  host_port_device u_host_port_device (.clk(clk), .reset(reset), .pins(u_host_port_if),
    .src_event(src_event), .ext_event(ext_event), .code_value(code_value),
    .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data), .bus_mode(bus_mode),
    .irq_active(irq_active));
  host_port_host u_host_port_host (.clk(clk), .reset(reset), .pins(u_host_port_if),
    .host_mode(host_mode), .req(req), .req_write(req_write), .req_addr(req_addr),
    .req_wdata(req_wdata), .busy(busy), .done(done), .rd_data(rd_data),
    .irq_seen(irq_seen));
  host_port_properties u_host_port_properties (.clk(clk), .reset(reset),
    .chip_sel_n(u_host_port_if.chip_sel_n), .read_not_write(u_host_port_if.read_not_write),
    .data_strobe_n(u_host_port_if.data_strobe_n), .ale(u_host_port_if.ale),
    .data_clock(u_host_port_if.data_clock), .host_bus_oe(u_host_port_if.host_bus_oe),
    .dev_bus_oe(u_host_port_if.dev_bus_oe), .irq_o(u_host_port_if.irq_o),
    .irq_oe(u_host_port_if.irq_oe));
  // write pulse lasts one cycle, so latch what it carried
  always @(posedge clk) begin
    if (wr_strobe === 1'b1) begin
      seen_addr <= wr_addr;
      seen_data <= wr_data;
    end
  end
  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check8
  task automatic check1(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s: expected %b, seen %b", what, exp, got);
    end
  endtask : check1
  // one access; req is dropped in the done cycle so it is not taken twice
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    #1;
    req = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    for (n = 0; n < 60; n++) begin
      @(posedge clk);
      #1;
      if (n == 0) check1("busy", 1'b1, busy);
      if (done === 1'b1) break;
    end
    req = 1'b0;
    check1("access done", 1'b1, done);
    if (n == 60) report_and_stop();
  endtask : access
  task automatic do_read(input logic [7:0] a, input logic [7:0] exp, input string what);
    access(1'b0, a, 8'h00);
    check8(what, exp, rd_data);
  endtask : do_read
  // one-cycle event pulses from the core side
  task automatic pulse(input logic [7:0] s, input logic [7:0] e);
    @(posedge clk);
    #1;
    src_event = s[7:1];
    ext_event = e;
    @(posedge clk);
    #1;
    src_event = 7'h00;
    ext_event = 8'h00;
  endtask : pulse
  // bound covers a full data clock period plus the sync stages
  task automatic wait_irq(input logic lvl);
    int n;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      #1;
      if (u_host_port_if.irq_n === lvl) break;
    end
    check1("interrupt pin", lvl, u_host_port_if.irq_n);
    check1("interrupt active", ~lvl, irq_active);
    if (n == 40) report_and_stop();
    // host view lags the pin by its sync stages
    repeat (3) @(posedge clk);
    #1;
    check1("interrupt seen", ~lvl, irq_seen);
  endtask : wait_irq
  task automatic hold_irq();
    repeat (30) @(posedge clk);
    #1;
    check1("interrupt pin held", 1'b1, u_host_port_if.irq_n);
    check1("interrupt not seen", 1'b0, irq_seen);
  endtask : hold_irq
  // ----------------------------------------------------------------
  // one full pass per bus type, each after its own reset
  // ----------------------------------------------------------------
  task automatic run_mode(input bus_mode_t m);
    host_mode = m;
    reset = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    check8("type in reset", 8'(mode_split), 8'(bus_mode));
    reset = 1'b0;
    // strap is taken late; an earlier latch pulse would be read as the strap
    repeat (2) @(posedge clk);
    access(1'b1, 8'h15, 8'hc3);
    check8("written address", 8'h15, seen_addr);
    check8("written data", 8'hc3, seen_data);
    check8("bus type", 8'(m), 8'(bus_mode));
    access(1'b1, status_addr, mask_reset);
    pulse(8'h08, 8'h20);
    wait_irq(1'b0);
    do_read(status_addr, 8'h09, "status");
    do_read(status_addr, 8'h01, "status again");
    do_read(ext_addr, 8'h20, "extended");
    do_read(status_addr, 8'h00, "status empty");
    wait_irq(1'b1);
    pulse(8'h04, 8'h00);
    wait_irq(1'b0);
    code_value = 8'h5a;
    do_read(status_addr, 8'h04, "code status");
    do_read(status_addr, 8'h04, "code kept");
    do_read(code_addr, 8'h5a, "code");
    do_read(status_addr, 8'h00, "code cleared");
    wait_irq(1'b1);
    access(1'b1, status_addr, 8'h08);
    pulse(8'h08, 8'h00);
    hold_irq();
    do_read(status_addr, 8'h00, "masked");
    access(1'b1, status_addr, 8'h00);
    wait_irq(1'b0);
    do_read(status_addr, 8'h08, "unmasked");
    wait_irq(1'b1);
    access(1'b1, status_addr, 8'h01);
    pulse(8'h00, 8'h02);
    hold_irq();
    do_read(status_addr, 8'h01, "masked summary");
    do_read(ext_addr, 8'h02, "extended masked");
    do_read(8'h10, 8'h00, "unmapped");
    $display("test done for bus type %s", m.name());
  endtask : run_mode
  // mux first, so the later passes show that reset leaves it
  initial begin
    run_mode(mode_mux);
    run_mode(mode_strobe);
    run_mode(mode_split);
    report_and_stop();
  end
endmodule : tb_top
